// >>> hdl/timer_setup_pkg.sv
// constants, field positions and state types of the timer setup block
// assumes a single ref_clk domain and an AHB-Lite register slave
package timer_setup_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFF_TIMER_MODE = 8'h00;
   localparam logic [7:0] OFF_TIMER_CONTROL = 8'h04;
   localparam logic [7:0] OFF_TT_CONTROL = 8'h08;
   localparam logic [7:0] OFF_TT_MODE = 8'h0C;
   localparam logic [7:0] OFF_COUNT_LOW_ZERO = 8'h10;
   localparam logic [7:0] OFF_COUNT_HIGH_ZERO = 8'h14;
   localparam logic [7:0] OFF_COUNT_LOW_ONE = 8'h18;
   localparam logic [7:0] OFF_COUNT_HIGH_ONE = 8'h1C;
   localparam logic [7:0] OFF_COUNT_LOW_TWO = 8'h20;
   localparam logic [7:0] OFF_COUNT_HIGH_TWO = 8'h24;
   localparam logic [7:0] OFF_RELOAD_LOW = 8'h28;
   localparam logic [7:0] OFF_RELOAD_HIGH = 8'h2C;
   localparam logic [7:0] OFF_CLOCK_MODE = 8'h30;
   // ==========================================================
   // field positions
   localparam int CNT_SEL = 2;
   localparam int GATE_SEL = 3;
   localparam int RUN_ZERO = 4;
   localparam int FLAG_ZERO = 5;
   localparam int RUN_ONE = 6;
   localparam int FLAG_ONE = 7;
   localparam int TT_CAP_SEL = 0;
   localparam int TT_CNT_SEL = 1;
   localparam int TT_RUN = 2;
   localparam int TT_EXT_EN = 3;
   localparam int TT_TX_BAUD = 4;
   localparam int TT_RX_BAUD = 5;
   localparam int TT_EXT_FLAG = 6;
   localparam int TT_FLAG = 7;
   localparam int TT_OUT_EN = 1;
   // ==========================================================
   // reset values and timing counts
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] MC_CLOCKS_STD = 4'hC;
   localparam logic [3:0] MC_CLOCKS_DOUBLE = 4'h6;
   localparam logic [1:0] TMODE_SPLIT = 2'h3;
   // ==========================================================
   // types
   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ = 2'b10
   } bus_phase_t;

   typedef enum logic [1:0]
   {
      TT_RELOAD = 2'b00,
      TT_CAPTURE = 2'b01,
      TT_BAUD = 2'b10
   } tt_mode_t;

   typedef struct packed {
      logic gate0;
      logic gate1;
      logic cnt0;
      logic cnt1;
      logic cnt2;
      logic trig;
   } pin_sample_t;

   typedef struct packed {
      logic [7:0] timer_mode_reg;
      logic [7:0] timer_control_reg;
      logic [7:0] third_timer_control_reg;
      logic [7:0] third_timer_mode_reg;
      logic double_speed;
      logic [1:0][7:0] cnt_lo;
      logic [1:0][7:0] cnt_hi;
      logic [7:0] count_low_two;
      logic [7:0] count_high_two;
      logic [7:0] reload_capture_low;
      logic [7:0] reload_capture_high;
      logic [3:0] pre;
      logic fast_pre;
      logic [1:0] gate_on;
      pin_sample_t pins;
      logic clk_out;
      logic clk_oe;
      logic baud_rx;
      logic baud_tx;
      bus_phase_t phase;
      logic [7:0] addr;
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } timer_state_t;
endpackage

// >>> hdl/timer_setup_and_clock_out.sv
// three timer/counters, timer 2 reload/capture/baud and clock output
// assumes pins synchronous to ref_clk, ref_clk taken as oscillator
//
// Functional notes
// - timer 0 low nibble: bits 1:0 mode, 04H counter, 08H gate.
// - without gate, timer 0 runs exactly while its run bit is set.
// - gated timer 0 with run bit set toggles on gate pin falling edge.
// - timer 1 high nibble; mode 3 halts it; run bit starts and stops.
// - gated timer 1 with run bit set toggles on gate pin falling edge.
// - timer 2 control selects auto-reload or capture, timer or counter.
// - baud settings 34H/24H/14H (and 36H/26H/16H) include the run bit.
// - without external trigger, reload only at overflow; capture mode just wraps.
// - trigger falling edge also captures or reloads, not in baud mode.
// - shared pin is timer 2 count input or 50% clock output.
// - output clock is oscillator over n times (65536 minus reload).
// - clock-output roll-overs raise no overflow flag.
// - baud generation and clock output may run together.
// - each count held as software-visible high and low bytes.
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module timer_setup_and_clock_out
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic gate_pin_zero,
   input wire logic gate_pin_one,
   input wire logic count_pin_zero,
   input wire logic count_pin_one,
   input wire logic third_timer_trigger_pin,
   input wire logic clock_output_pin_in,
   output logic clock_output_pin_out,
   output logic clock_output_pin_oe,
   output logic baud_tick_rx,
   output logic baud_tick_tx
);
   import timer_setup_pkg::*;

   timer_state_t s;
   timer_state_t next_s;

   // ==========================================================
   // helpers
   function automatic logic [16:0] step_timer(input logic [1:0] mode,
      input logic [7:0] lo, input logic [7:0] hi);
      logic [12:0] c13;
      logic [15:0] c16;
      logic [16:0] r;
      c13 = {hi, lo[4:0]};
      c16 = {hi, lo};
      r = {1'b0, hi, lo};
      case (mode)
         2'b00:
         begin
            c13 = c13 + 13'h0001;
            r = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
         end
         2'b01:
         begin
            c16 = c16 + 16'h0001;
            r = {&{hi, lo}, c16};
         end
         2'b10:
            r = {&lo, hi, (&lo) ? hi : lo + 8'h01};
         default:
            r = {&lo, hi, lo + 8'h01};
      endcase
      return r;
   endfunction

   function automatic tt_mode_t tt_mode_of(input logic [7:0] ctl);
      tt_mode_t m;
      if (ctl[TT_TX_BAUD] | ctl[TT_RX_BAUD])
         m = TT_BAUD;
      else if (ctl[TT_CAP_SEL])
         m = TT_CAPTURE;
      else
         m = TT_RELOAD;
      return m;
   endfunction

   // ==========================================================
   // next state
   logic mc_tick;
   logic fast_tick;
   logic clkout_mode;
   logic tt_tick;
   logic trig_fall;
   logic [1:0] run;
   logic [1:0] adv;
   logic [1:0] set_tf;
   logic set_tf2;
   logic set_exf2;
   logic [1:0] gfall;
   logic [1:0] cfall;
   logic [3:0] nib;
   logic [16:0] st;
   logic [15:0] c2;
   tt_mode_t t2m;

   always_comb
   begin
      next_s = s;
      set_tf = 2'b00;
      set_tf2 = 1'b0;
      set_exf2 = 1'b0;
      adv = 2'b00;
      run = 2'b00;
      nib = 4'h0;
      st = 17'h00000;
      t2m = tt_mode_of(s.third_timer_control_reg);
      // machine cycle prescaler, 12 or 6 clocks; not an exact compare
      // so a count left high by a speed change wraps at once
      mc_tick = s.pre >= ((s.double_speed ? MC_CLOCKS_DOUBLE : MC_CLOCKS_STD)
         - 4'h1);
      next_s.pre = mc_tick ? 4'h0 : s.pre + 4'h1;
      // fast rate: osc/2 standard, osc/1 double, so n becomes 4 or 2
      next_s.fast_pre = ~s.fast_pre;
      fast_tick = s.double_speed | s.fast_pre;
      next_s.pins.gate0 = gate_pin_zero;
      next_s.pins.gate1 = gate_pin_one;
      next_s.pins.cnt0 = count_pin_zero;
      next_s.pins.cnt1 = count_pin_one;
      next_s.pins.cnt2 = clock_output_pin_in;
      next_s.pins.trig = third_timer_trigger_pin;
      gfall = {s.pins.gate1 & ~gate_pin_one, s.pins.gate0 & ~gate_pin_zero};
      cfall = {s.pins.cnt1 & ~count_pin_one, s.pins.cnt0 & ~count_pin_zero};
      trig_fall = s.pins.trig & ~third_timer_trigger_pin;

      // timers 0 and 1
      for (int i = 0; i < 2; i++)
      begin
         nib = i == 0 ? s.timer_mode_reg[3:0] : s.timer_mode_reg[7:4];
         run[i] = i == 0 ? s.timer_control_reg[RUN_ZERO]
            : s.timer_control_reg[RUN_ONE];
         if (!run[i])
            next_s.gate_on[i] = 1'b0;
         else if (nib[GATE_SEL] && gfall[i])
            next_s.gate_on[i] = ~s.gate_on[i];
         if (nib[GATE_SEL])
            run[i] = run[i] & s.gate_on[i];
         adv[i] = run[i]
            & (nib[CNT_SEL] ? cfall[i] : mc_tick);
         if (i == 1 && nib[1:0] == TMODE_SPLIT)
            adv[i] = 1'b0;
         if (adv[i])
         begin
            st = step_timer(nib[1:0], s.cnt_lo[i], s.cnt_hi[i]);
            next_s.cnt_hi[i] = st[15:8];
            next_s.cnt_lo[i] = st[7:0];
            set_tf[i] = st[16];
         end
      end
      // split mode: timer 0 high byte runs on timer 1 run bit
      if (s.timer_mode_reg[1:0] == TMODE_SPLIT && mc_tick
         && s.timer_control_reg[RUN_ONE])
      begin
         next_s.cnt_hi[0] = s.cnt_hi[0] + 8'h01;
         set_tf[1] = &s.cnt_hi[0];
      end

      // timer 2
      clkout_mode = s.third_timer_mode_reg[TT_OUT_EN]
         & ~s.third_timer_control_reg[TT_CNT_SEL];
      next_s.clk_oe = clkout_mode;
      next_s.baud_rx = 1'b0;
      next_s.baud_tx = 1'b0;
      if (s.third_timer_control_reg[TT_CNT_SEL])
         tt_tick = s.pins.cnt2 & ~clock_output_pin_in;
      else if (t2m == TT_BAUD || clkout_mode)
         tt_tick = fast_tick;
      else
         tt_tick = mc_tick;
      tt_tick = tt_tick & s.third_timer_control_reg[TT_RUN];
      c2 = {s.count_high_two, s.count_low_two};
      if (tt_tick)
      begin
         if (&c2)
         begin
            // overflow reloads, except capture mode wraps
            if (t2m == TT_CAPTURE)
               c2 = 16'h0000;
            else
               c2 = {s.reload_capture_high, s.reload_capture_low};
            set_tf2 = t2m != TT_BAUD && !clkout_mode;
            next_s.baud_rx = t2m == TT_BAUD
               && s.third_timer_control_reg[TT_RX_BAUD];
            next_s.baud_tx = t2m == TT_BAUD
               && s.third_timer_control_reg[TT_TX_BAUD];
            if (clkout_mode)
               next_s.clk_out = ~s.clk_out;
         end
         else
            c2 = c2 + 16'h0001;
      end
      if (trig_fall && s.third_timer_control_reg[TT_EXT_EN])
      begin
         set_exf2 = 1'b1;
         // the edge never reloads a baud generator
         if (t2m == TT_CAPTURE)
         begin
            next_s.reload_capture_high = s.count_high_two;
            next_s.reload_capture_low = s.count_low_two;
         end
         else if (t2m == TT_RELOAD)
            c2 = {s.reload_capture_high, s.reload_capture_low};
      end
      next_s.count_high_two = c2[15:8];
      next_s.count_low_two = c2[7:0];

      // ==========================================================
      // bus data phase; a software write overrides a count update
      next_s.hresp = 1'b0;
      next_s.hreadyout = 1'b1;
      if (s.phase == BUS_WRITE)
      begin
         case (s.addr)
            OFF_TIMER_MODE: next_s.timer_mode_reg = hwdata[7:0];
            OFF_TIMER_CONTROL: next_s.timer_control_reg = hwdata[7:0];
            OFF_TT_CONTROL: next_s.third_timer_control_reg = hwdata[7:0];
            OFF_TT_MODE: next_s.third_timer_mode_reg = hwdata[7:0];
            OFF_COUNT_LOW_ZERO: next_s.cnt_lo[0] = hwdata[7:0];
            OFF_COUNT_HIGH_ZERO: next_s.cnt_hi[0] = hwdata[7:0];
            OFF_COUNT_LOW_ONE: next_s.cnt_lo[1] = hwdata[7:0];
            OFF_COUNT_HIGH_ONE: next_s.cnt_hi[1] = hwdata[7:0];
            OFF_COUNT_LOW_TWO: next_s.count_low_two = hwdata[7:0];
            OFF_COUNT_HIGH_TWO: next_s.count_high_two = hwdata[7:0];
            OFF_RELOAD_LOW: next_s.reload_capture_low = hwdata[7:0];
            OFF_RELOAD_HIGH: next_s.reload_capture_high = hwdata[7:0];
            OFF_CLOCK_MODE: next_s.double_speed = hwdata[0];
            default: next_s.hresp = 1'b0;
         endcase
      end
      if (s.phase == BUS_READ)
      begin
         case (s.addr)
            OFF_TIMER_MODE: next_s.hrdata = {24'h0, s.timer_mode_reg};
            OFF_TIMER_CONTROL: next_s.hrdata = {24'h0, s.timer_control_reg};
            OFF_TT_CONTROL:
               next_s.hrdata = {24'h0, s.third_timer_control_reg};
            OFF_TT_MODE: next_s.hrdata = {24'h0, s.third_timer_mode_reg};
            OFF_COUNT_LOW_ZERO: next_s.hrdata = {24'h0, s.cnt_lo[0]};
            OFF_COUNT_HIGH_ZERO: next_s.hrdata = {24'h0, s.cnt_hi[0]};
            OFF_COUNT_LOW_ONE: next_s.hrdata = {24'h0, s.cnt_lo[1]};
            OFF_COUNT_HIGH_ONE: next_s.hrdata = {24'h0, s.cnt_hi[1]};
            OFF_COUNT_LOW_TWO: next_s.hrdata = {24'h0, s.count_low_two};
            OFF_COUNT_HIGH_TWO: next_s.hrdata = {24'h0, s.count_high_two};
            OFF_RELOAD_LOW: next_s.hrdata = {24'h0, s.reload_capture_low};
            OFF_RELOAD_HIGH: next_s.hrdata = {24'h0, s.reload_capture_high};
            OFF_CLOCK_MODE: next_s.hrdata = {31'h0, s.double_speed};
            default: next_s.hrdata = 32'h0000_0000;
         endcase
      end
      // flags set by hardware win over a clearing write
      next_s.timer_control_reg[FLAG_ZERO] =
         next_s.timer_control_reg[FLAG_ZERO] | set_tf[0];
      next_s.timer_control_reg[FLAG_ONE] =
         next_s.timer_control_reg[FLAG_ONE] | set_tf[1];
      next_s.third_timer_control_reg[TT_FLAG] =
         next_s.third_timer_control_reg[TT_FLAG] | set_tf2;
      next_s.third_timer_control_reg[TT_EXT_FLAG] =
         next_s.third_timer_control_reg[TT_EXT_FLAG] | set_exf2;

      // address phase; reads take one wait so data reflects prior writes
      next_s.phase = BUS_IDLE;
      if (hsel && htrans[1] && hready)
      begin
         next_s.addr = haddr[7:0];
         next_s.phase = hwrite ? BUS_WRITE : BUS_READ;
         next_s.hreadyout = hwrite;
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.phase <= BUS_IDLE;
         s.hreadyout <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign hrdata = s.hrdata;
   assign hreadyout = s.hreadyout;
   assign hresp = s.hresp;
   assign clock_output_pin_out = s.clk_out;
   assign clock_output_pin_oe = s.clk_oe;
   assign baud_tick_rx = s.baud_rx;
   assign baud_tick_tx = s.baud_tx;
endmodule

// >>> verif/timer_setup_monitor.sv
// assertions on the bus and clock-output ports of the timer block
// assumes binding into timer_setup_and_clock_out, one ref_clk domain
`timescale 1ns/100ps
module timer_setup_monitor
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic clock_output_pin_out,
   input wire logic clock_output_pin_oe,
   input wire logic baud_tick_rx,
   input wire logic baud_tick_tx
);
   wire take = hsel && htrans[1] && hready;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // register bus
   read_wait_a: assert property (
      take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read data phase is not one wait state");
   write_nowait_a: assert property (take && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   wait_cause_a: assert property (
      $fell(hreadyout) |-> $past(take && !hwrite))
      else $error("wait state without a read");
   data_hold_a: assert property ($changed(hrdata) |-> $past(!hreadyout))
      else $error("read data changed outside a read");
   data_with_ready_a: assert property ($changed(hrdata) |-> hreadyout)
      else $error("read data changed while stalled");
   byte_wide_a: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   okay_resp_a: assert property (!hresp)
      else $error("response other than okay");
   // ==========================================================
   // clock output pin
   // three cycles so a clear that lags the enable by one edge is allowed
   pin_idle_a: assert property (
      !clock_output_pin_oe [*3] |-> $stable(clock_output_pin_out))
      else $error("clock output moved while not enabled");
   cover property (take && !hwrite);
   cover property ($rose(clock_output_pin_oe));
   cover property (baud_tick_rx && baud_tick_tx);
endmodule

bind timer_setup_and_clock_out timer_setup_monitor mon
(
   .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp),
   .clock_output_pin_out(clock_output_pin_out),
   .clock_output_pin_oe(clock_output_pin_oe),
   .baud_tick_rx(baud_tick_rx), .baud_tick_tx(baud_tick_tx)
);

// >>> verif/timer_setup_and_clock_out_tb.sv
// self-checking bench for the timer setup and clock-output block
// assumes the design package; bench is sole AHB-Lite master
`timescale 1ns/100ps
module timer_setup_and_clock_out_tb;
   import timer_setup_pkg::*;
   logic ref_clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h14F44;
   logic hreadyout, hresp, pout, poe, trx, ttx;
   // idle high: count0, count1, gate0, gate1, trigger, timer 2 count
   logic [5:0] pins = 6'h3F;
   logic [7:0] b, c;
   logic [15:0] v, w, r, xc, xr;
   int cyc, mismatches, n_checks, nrx, ntx, n, e, ts, mc, k, a1, a2, a3;
   logic [7:0] t2m [8] = '{8'h00, 8'h01, 8'h02, 8'h03,
                           8'h08, 8'h09, 8'h0A, 8'h0B};
   logic [7:0] bm [4] = '{8'h04, 8'h34, 8'h24, 8'h14};

   timer_setup_and_clock_out DUT
   (
      .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .gate_pin_zero(pins[2]), .gate_pin_one(pins[3]),
      .count_pin_zero(pins[0]), .count_pin_one(pins[1]),
      .third_timer_trigger_pin(pins[4]), .clock_output_pin_in(pins[5]),
      .clock_output_pin_out(pout), .clock_output_pin_oe(poe),
      .baud_tick_rx(trx), .baud_tick_tx(ttx)
   );

   // ==========================================================
   // clock, cycle count, tick count, timeout
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      // non-blocking so readers at this edge all see the same count
      cyc <= cyc + 1;
      if (trx === 1'h1)
         nrx++;
      if (ttx === 1'h1)
         ntx++;
      if (cyc > 20000)
      begin
         mismatches++;
         results();
      end
   end

   // ==========================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input string what, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic ticks(input int m);
      repeat (m) @(posedge ref_clk);
   endtask
   // address phase held until hready, then data phase until hready
   task automatic bus(input logic wr, input logic [7:0] a, wd,
                      output logic [7:0] rd);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge ref_clk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge ref_clk); while (hreadyout !== 1'h1);
      rd = hrdata[7:0];
   endtask
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] x;
      bus(1'h1, a, d, x);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      bus(1'h0, a, 8'h00, d);
   endtask
   task automatic cnt(input int t, output logic [15:0] q);
      rd(OFF_COUNT_LOW_ZERO + 8'(8 * t), q[7:0]);
      rd(OFF_COUNT_HIGH_ZERO + 8'(8 * t), q[15:8]);
   endtask
   task automatic setc(input int t, input logic [15:0] q);
      wr(OFF_COUNT_LOW_ZERO + 8'(8 * t), q[7:0]);
      wr(OFF_COUNT_HIGH_ZERO + 8'(8 * t), q[15:8]);
   endtask
   task automatic pulse(input int p);
      pins[p] <= 1'h0;
      ticks(3);
      pins[p] <= 1'h1;
      ticks(3);
   endtask
   task automatic edge_t(output int at);
      logic p;
      p = pout;
      do @(posedge ref_clk); while (pout === p);
      at = cyc;
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'h1;
      @(posedge ref_clk);
      for (int a = 0; a <= 8'h40; a += 4)
      begin
         rd(8'(a), b);
         check("reset value", {8'h0, b}, {8'h0, REG_RESET});
      end
      wr(8'h40, 8'h5A);
      rd(8'h40, b);
      check("unmapped read", {8'h0, b}, 16'h0);
      setc(0, 16'hA55A);
      cnt(0, v);
      check("count bytes", v, 16'hA55A);
      $display("test map done");
      for (int sp = 0; sp < 2; sp++)
      begin
         mc = sp ? 6 : 12;
         n = 4 + int'(rnd() % 20);
         wr(OFF_CLOCK_MODE, 8'(sp));
         wr(OFF_TIMER_MODE, 8'h01);
         setc(0, 16'h0);
         wr(OFF_TIMER_CONTROL, 8'h10);
         ts = cyc;
         ticks(n * mc);
         wr(OFF_TIMER_CONTROL, 8'h00);
         e = (cyc - ts) / mc;
         cnt(0, v);
         check("machine ticks", {15'h0, v >= 16'(e) && v <= 16'(e + 1)},
               16'h1);
         ticks(40);
         cnt(0, w);
         check("halted count", w, v);
      end
      wr(OFF_CLOCK_MODE, 8'h00);
      $display("test timer done");
      for (int t = 0; t < 2; t++)
      begin
         k = 1 + int'(rnd() % 9);
         wr(OFF_TIMER_MODE, t ? 8'h50 : 8'h05);
         setc(t, 16'h0);
         wr(OFF_TIMER_CONTROL, t ? 8'h40 : 8'h10);
         repeat (k) pulse(t);
         wr(OFF_TIMER_CONTROL, 8'h00);
         cnt(t, v);
         check("event count", v, 16'(k));
         wr(OFF_TIMER_MODE, t ? 8'h90 : 8'h09);
         setc(t, 16'h0);
         wr(OFF_TIMER_CONTROL, t ? 8'h40 : 8'h10);
         ticks(60);
         cnt(t, v);
         check("gated idle", v, 16'h0);
         pulse(t + 2);
         ticks(120);
         pulse(t + 2);
         cnt(t, v);
         ticks(40);
         cnt(t, w);
         check("gated run", {15'h0, v != 16'h0}, 16'h1);
         check("gated stop", w, v);
         wr(OFF_TIMER_CONTROL, 8'h00);
      end
      wr(OFF_TIMER_MODE, 8'h30);
      setc(1, 16'h0);
      wr(OFF_TIMER_CONTROL, 8'h40);
      ticks(60);
      cnt(1, v);
      check("mode three halt", v, 16'h0);
      wr(OFF_TIMER_CONTROL, 8'h00);
      // split mode: timer 0 high byte runs on the timer 1 run bit
      wr(OFF_TIMER_MODE, 8'h03);
      setc(0, 16'h0);
      wr(OFF_TIMER_CONTROL, 8'h40);
      ts = cyc;
      ticks(120);
      wr(OFF_TIMER_CONTROL, 8'h00);
      e = (cyc - ts) / 12;
      cnt(0, v);
      check("split high",
            {15'h0, v[15:8] >= 8'(e) && v[15:8] <= 8'(e + 1)}, 16'h1);
      check("split low", {8'h0, v[7:0]}, 16'h0);
      $display("test gate done");
      for (int i = 0; i < 8; i++)
      begin
         setc(2, 16'h1234);
         wr(OFF_RELOAD_LOW, 8'h00);
         wr(OFF_RELOAD_HIGH, 8'hFF);
         wr(OFF_TT_CONTROL, t2m[i]);
         pulse(4);
         cnt(2, v);
         rd(OFF_RELOAD_LOW, b);
         rd(OFF_RELOAD_HIGH, c);
         xc = (t2m[i][3] && !t2m[i][0]) ? 16'hFF00 : 16'h1234;
         xr = (t2m[i][3] && t2m[i][0]) ? 16'h1234 : 16'hFF00;
         check("trigger count", v, xc);
         check("trigger capture", {c, b}, xr);
      end
      k = 1 + int'(rnd() % 9);
      setc(2, 16'h0);
      wr(OFF_TT_CONTROL, 8'h02);
      wr(OFF_TT_CONTROL, 8'h06);
      repeat (k) pulse(5);
      wr(OFF_TT_CONTROL, 8'h00);
      cnt(2, v);
      check("pin event count", v, 16'(k));
      $display("test trigger done");
      r = 16'hFFF0 + 16'(rnd() % 15);
      wr(OFF_RELOAD_LOW, r[7:0]);
      wr(OFF_RELOAD_HIGH, r[15:8]);
      setc(2, r);
      wr(OFF_TT_MODE, 8'h02);
      for (int i = 0; i < 4; i++)
      begin
         wr(OFF_TT_CONTROL, bm[i]);
         edge_t(a1);
         edge_t(a1);
         nrx = 0;
         ntx = 0;
         edge_t(a2);
         edge_t(a3);
         check("half period", 16'(a2 - a1), 16'(4 * (65536 - r) / 2));
         check("output enable", {15'h0, poe}, 16'h1);
         check("rx ticks", {15'h0, nrx > 0}, {15'h0, bm[i][5]});
         check("tx ticks", {15'h0, ntx > 0}, {15'h0, bm[i][4]});
         rd(OFF_TT_CONTROL, b);
         check("no overflow flag", {8'h0, b}, {8'h0, bm[i]});
      end
      // six-clock mode halves the divider
      wr(OFF_CLOCK_MODE, 8'h01);
      edge_t(a1);
      edge_t(a1);
      edge_t(a2);
      check("fast half period", 16'(a2 - a1), 16'(2 * (65536 - r) / 2));
      wr(OFF_CLOCK_MODE, 8'h00);
      wr(OFF_TT_CONTROL, 8'h00);
      wr(OFF_TT_MODE, 8'h00);
      ticks(3);
      check("pin released", {15'h0, poe}, 16'h0);
      $display("test clock out done");
      results();
   end
endmodule
